// ---- mbr_pkg.sv ----
package mbr_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned START_PULSE_NS  = 100;
  localparam int unsigned START_PULSE_CYC =
    (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUF_DEPTH = 2048;
  localparam int unsigned PTR_W     = 11;
  localparam int unsigned CNT_W     = 12;
  localparam int unsigned FIFO_DEPTH = 8;

  localparam logic [7:0] OFS_BATCH = 8'h00;
  localparam logic [7:0] OFS_AVAIL = 8'h04;
  localparam logic [7:0] OFS_FETCH = 8'h08;
  localparam logic [7:0] OFS_RDPTR = 8'h0c;
  localparam logic [7:0] OFS_GATE  = 8'h10;
  localparam logic [7:0] OFS_DUR   = 8'h14;
  localparam logic [7:0] OFS_PER   = 8'h18;
  localparam logic [7:0] OFS_STAT  = 8'h1c;

  localparam int unsigned GATE_MODE_LSB   = 0;
  localparam int unsigned GATE_MASTER_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_FULL_BIT   = 1;

  localparam logic [CNT_W-1:0] BATCH_MIN = 12'h001;
  localparam logic [CNT_W-1:0] BATCH_MAX = 12'h800;
  localparam logic [CNT_W-1:0] BATCH_RST = 12'h800;
  localparam logic [31:0]      DUR_RST   = 32'h0000_0004;
  localparam logic [31:0]      PER_RST   = 32'h0000_0028;

  typedef enum logic [2:0] {
    MBR_MARKER   = 3'b000,
    MBR_BURST    = 3'b001,
    MBR_EXT      = 3'b010,
    MBR_EXTTRIG  = 3'b011,
    MBR_PERIODIC = 3'b100
  } mbr_gate_mode_e;

  typedef enum logic {
    MBR_IDLE  = 1'b0,
    MBR_FETCH = 1'b1
  } mbr_fetch_state_e;

  typedef struct packed {
    mbr_gate_mode_e mode;
    logic           master;
  } mbr_gate_cfg_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mbr_bus_req_s;
endpackage : mbr_pkg

// ---- mbr_readback.sv ----
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps

module mbr_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             load;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign load     = (!out_valid || out_ready) && (cnt != '0);

  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (ce) begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (load) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      if (load) begin
        out_valid <= 1'b1;
        out_data  <= mem[rp];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : mbr_fifo

module mbr_readback #(
  parameter int unsigned ENTRY_W = 32
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  ce,
  input  wire mbr_pkg::mbr_bus_req_s bus_req,
  output logic [31:0]                rd_data,
  input  wire logic                  entry_valid,
  input  wire logic [ENTRY_W-1:0]    entry_data,
  output logic                       stream_valid,
  input  wire logic                  stream_ready,
  output logic [ENTRY_W-1:0]         stream_data,
  input  wire logic                  sweep_gate,
  input  wire logic                  sweep_trig,
  input  wire logic                  sweep_armed,
  input  wire logic                  burst_gate,
  input  wire logic                  mio_in,
  output logic                       mio_out,
  output logic                       mio_oe_n,
  output logic                       buf_gate,
  output logic                       trig_in,
  output logic                       arm_in
);
  import mbr_pkg::*;

  logic [ENTRY_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]   wr_ptr;
  logic [PTR_W-1:0]   rd_ptr;
  logic [CNT_W-1:0]   count;
  logic [CNT_W-1:0]   batch;
  logic [CNT_W-1:0]   remain;
  logic [CNT_W-1:0]   last_fetch;
  logic [CNT_W-1:0]   next_n;
  logic [31:0]        dur_cfg;
  logic [31:0]        per_cfg;
  mbr_gate_cfg_s      gcfg;
  mbr_fetch_state_e   state;
  logic               full;
  logic               pop;
  logic               inc;
  logic               fifo_ready;
  logic               wr_fetch;
  logic               wr_ptr_req;
  logic               mio_s1;
  logic               mio_s2;
  logic               mio_d;
  logic               mio_rise;
  logic [31:0]        dur_cnt;
  logic [31:0]        per_cnt;
  logic [2:0]         pulse_cnt;
  logic               per_start;
  logic               timed_start;
  logic               next_gate;
  logic               next_mio_out;
  logic               next_oe_n;

  assign full       = (count == CNT_W'(BUF_DEPTH));
  assign pop        = (state == MBR_FETCH) && fifo_ready && (remain != '0);
  assign inc        = entry_valid && !(full && !pop);
  assign wr_fetch   = bus_req.wr && (bus_req.addr == OFS_FETCH);
  assign wr_ptr_req = bus_req.wr && (bus_req.addr == OFS_RDPTR) && (state == MBR_IDLE);
  assign next_n     = (batch < count) ? batch : count;

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      batch   <= BATCH_RST;
      gcfg    <= '{mode: MBR_MARKER, master: 1'b0};
      dur_cfg <= DUR_RST;
      per_cfg <= PER_RST;
    end else if (ce && bus_req.wr) begin
      case (bus_req.addr)
        OFS_BATCH: begin
          if (bus_req.wdata < 32'(BATCH_MIN)) begin
            batch <= BATCH_MIN;
          end else if (bus_req.wdata > 32'(BATCH_MAX)) begin
            batch <= BATCH_MAX;
          end else begin
            batch <= bus_req.wdata[CNT_W-1:0];
          end
        end
        OFS_GATE: begin
          gcfg.mode   <= mbr_gate_mode_e'(bus_req.wdata[GATE_MODE_LSB +: 3]);
          gcfg.master <= bus_req.wdata[GATE_MASTER_BIT];
        end
        OFS_DUR: dur_cfg <= bus_req.wdata;
        OFS_PER: per_cfg <= bus_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // Register reads, one cycle later
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0000_0000;
    end else if (ce) begin
      rd_data <= 32'h0000_0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          OFS_BATCH: rd_data <= 32'(batch);
          OFS_AVAIL: rd_data <= 32'(count);
          OFS_FETCH: rd_data <= 32'(last_fetch);
          OFS_RDPTR: rd_data <= 32'(rd_ptr);
          OFS_GATE:  rd_data <= 32'({gcfg.master, 1'b0, gcfg.mode});
          OFS_DUR:   rd_data <= dur_cfg;
          OFS_PER:   rd_data <= per_cfg;
          OFS_STAT:  rd_data <= 32'({full, state == MBR_FETCH});
          default:   rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Circular store
  always_ff @(posedge sys_clk) begin
    if (ce && entry_valid) begin
      buf_mem[wr_ptr] <= entry_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
    end else if (ce && entry_valid) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer and unread count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (wr_ptr_req) begin
        rd_ptr <= bus_req.wdata[PTR_W-1:0];
        count  <= CNT_W'(wr_ptr - bus_req.wdata[PTR_W-1:0]) + CNT_W'(entry_valid);
      end else begin
        if (pop || (entry_valid && full)) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        count <= count + CNT_W'(inc) - CNT_W'(pop);
      end
    end
  end

  // Fetch engine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= MBR_IDLE;
      remain     <= '0;
      last_fetch <= '0;
    end else if (ce) begin
      case (state)
        MBR_IDLE: begin
          if (wr_fetch) begin
            last_fetch <= next_n;
            remain     <= next_n;
            if (next_n != '0) begin
              state <= MBR_FETCH;
            end
          end
        end
        MBR_FETCH: begin
          if (pop) begin
            remain <= remain - 1'b1;
            if (remain == BATCH_MIN) begin
              state <= MBR_IDLE;
            end
          end
        end
        default: state <= MBR_IDLE;
      endcase
    end
  end

  mbr_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (pop),
    .in_ready  (fifo_ready),
    .in_data   (buf_mem[rd_ptr]),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_data)
  );

  // Shared line synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mio_s1 <= 1'b0;
      mio_s2 <= 1'b0;
      mio_d  <= 1'b0;
    end else if (ce) begin
      mio_s1 <= mio_in;
      mio_s2 <= mio_s1;
      mio_d  <= mio_s2;
    end
  end

  assign mio_rise    = mio_s2 && !mio_d;
  assign per_start   = (gcfg.mode == MBR_PERIODIC) && gcfg.master && (per_cnt == '0);
  assign timed_start = ((gcfg.mode == MBR_EXTTRIG) && mio_rise) ||
                       ((gcfg.mode == MBR_PERIODIC) && !gcfg.master && mio_rise) ||
                       per_start;

  // Period, duration and pulse timers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dur_cnt   <= '0;
      per_cnt   <= '0;
      pulse_cnt <= '0;
    end else if (ce) begin
      if (timed_start) begin
        dur_cnt <= dur_cfg;
      end else if (dur_cnt != '0) begin
        dur_cnt <= dur_cnt - 1'b1;
      end
      if ((gcfg.mode != MBR_PERIODIC) || !gcfg.master) begin
        per_cnt <= '0;
      end else if (per_start || (per_cfg == '0)) begin
        per_cnt <= (per_cfg == '0) ? '0 : per_cfg - 1'b1;
      end else begin
        per_cnt <= per_cnt - 1'b1;
      end
      if (per_start) begin
        pulse_cnt <= 3'(START_PULSE_CYC);
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end

  // Gate source and line drive per mode
  always_comb begin
    next_gate    = 1'b0;
    next_mio_out = 1'b0;
    next_oe_n    = 1'b1;
    case (gcfg.mode)
      MBR_MARKER: begin
        next_gate    = sweep_gate;
        next_mio_out = gcfg.master ? sweep_trig : sweep_armed;
        next_oe_n    = 1'b0;
      end
      MBR_BURST: begin
        next_gate    = gcfg.master ? burst_gate : mio_s2;
        next_mio_out = gcfg.master && burst_gate;
        next_oe_n    = !gcfg.master;
      end
      MBR_EXT:     next_gate = mio_s2;
      MBR_EXTTRIG: next_gate = (dur_cnt != '0);
      MBR_PERIODIC: begin
        next_gate    = (dur_cnt != '0);
        next_mio_out = gcfg.master && (pulse_cnt != '0);
        next_oe_n    = !gcfg.master;
      end
      default: next_gate = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_gate <= 1'b0;
      mio_out  <= 1'b0;
      mio_oe_n <= 1'b1;
      trig_in  <= 1'b0;
      arm_in   <= 1'b0;
    end else if (ce) begin
      buf_gate <= next_gate;
      mio_out  <= next_mio_out;
      mio_oe_n <= next_oe_n;
      trig_in  <= (gcfg.mode == MBR_MARKER) && !gcfg.master && mio_s2;
      arm_in   <= (gcfg.mode == MBR_MARKER) && gcfg.master && mio_s2;
    end
  end

  AST_BATCH_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (batch >= BATCH_MIN) && (batch <= BATCH_MAX)) else $error("batch out of range");
  AST_AVAIL_READ: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    bus_req.rd && (bus_req.addr == OFS_AVAIL) |=> rd_data == 32'($past(count)))
    else $error("avail read wrong");
  AST_FETCH_CAP: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    wr_fetch && (state == MBR_IDLE) |=>
      (last_fetch <= $past(batch)) && (last_fetch <= $past(count)))
    else $error("fetch exceeds cap");
  AST_FETCH_EMPTY: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    wr_fetch && (state == MBR_IDLE) && (count == '0) |=>
      (state == MBR_IDLE) && $stable(rd_ptr)) else $error("empty fetch moved");
  AST_PTR_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    wr_ptr_req |=> rd_ptr == $past(bus_req.wdata[PTR_W-1:0]))
    else $error("pointer write lost");
  AST_PTR_ADV: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    pop |=> rd_ptr == $past(rd_ptr) + 1'b1) else $error("pointer not advanced");
  AST_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    entry_valid && (wr_ptr == '1) |=> (wr_ptr == '0) && (count <= CNT_W'(BUF_DEPTH)))
    else $error("write pointer did not wrap");
  AST_START_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    per_start && (per_cfg > 32'h8) |=> ##1 mio_out [*4] ##1 !mio_out)
    else $error("start pulse length wrong");
  AST_EXT_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    (gcfg.mode == MBR_EXT) |=> buf_gate == $past(mio_s2)) else $error("ext gate lag");
  AST_TRIG_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    (gcfg.mode == MBR_EXTTRIG) && mio_rise && (dur_cfg != '0) |=> ##1 buf_gate)
    else $error("trigger did not open gate");
  AST_MARKER_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
    (gcfg.mode == MBR_MARKER) |=> buf_gate == $past(sweep_gate))
    else $error("marker gate mismatch");
endmodule : mbr_readback

// ---- mbr_peer.sv ----
`timescale 1ns/1ps

module mbr_peer (
  input  wire logic dut_out,
  input  wire logic dut_oe_n,
  input  wire logic peer_en,
  input  wire logic peer_drv,
  output logic      mio_line
);
  // Shared line, weak pull-down when nobody drives
  always_comb begin
    if (!dut_oe_n && peer_en) begin
      mio_line = 1'bx;
    end else if (!dut_oe_n) begin
      mio_line = dut_out;
    end else if (peer_en) begin
      mio_line = peer_drv;
    end else begin
      mio_line = 1'b0;
    end
  end
endmodule : mbr_peer

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
  import mbr_pkg::*;
  logic         sys_clk;
  logic         rst_b;
  mbr_bus_req_s bus_req;
  logic [31:0]  rd_data;
  logic         entry_valid;
  logic [31:0]  entry_data;
  logic         stream_valid;
  logic         stream_ready;
  logic [31:0]  stream_data;
  logic         sweep_gate;
  logic         sweep_trig;
  logic         sweep_armed;
  logic         burst_gate;
  logic         mio_line;
  logic         mio_out;
  logic         mio_oe_n;
  logic         buf_gate;
  logic         trig_in;
  logic         arm_in;
  logic         peer_en;
  logic         peer_drv;
  logic [31:0]  mem [0:2047];
  int           errors;
  int           samples_checked;
  int           wp;
  int           rp;
  int           cnt;
  int           seq;
  int           got;
  int           k;

  mbr_readback #(.ENTRY_W(32)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .bus_req(bus_req), .rd_data(rd_data),
    .entry_valid(entry_valid), .entry_data(entry_data), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data), .sweep_gate(sweep_gate),
    .sweep_trig(sweep_trig), .sweep_armed(sweep_armed), .burst_gate(burst_gate),
    .mio_in(mio_line), .mio_out(mio_out), .mio_oe_n(mio_oe_n), .buf_gate(buf_gate),
    .trig_in(trig_in), .arm_in(arm_in)
  );

  mbr_peer u_peer (
    .dut_out(mio_out), .dut_oe_n(mio_oe_n), .peer_en(peer_en), .peer_drv(peer_drv),
    .mio_line(mio_line)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    @(negedge sys_clk);
    chk(rd_data, want);
  endtask : rdc

  function automatic logic [31:0] gcfg(input mbr_gate_mode_e m, input logic ms);
    return {29'h0, m} | ({31'h0, ms} << GATE_MASTER_BIT);
  endfunction : gcfg

  // Store entries, dropping the oldest once full
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      entry_valid <= 1'b1;
      entry_data  <= seq;
      mem[wp] = seq;
      wp = (wp + 1) % 2048;
      seq++;
      if (cnt == 2048) rp = (rp + 1) % 2048;
      else cnt++;
    end
    @(posedge sys_clk);
    entry_valid <= 1'b0;
  endtask : push

  task automatic wait_got(input int n);
    for (int i = 0; i < 300 && got < n; i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    chk(got, n);
  endtask : wait_got

  always @(negedge sys_clk) begin
    if (stream_valid === 1'b1 && stream_ready === 1'b1) begin
      chk(stream_data, mem[rp]);
      rp = (rp + 1) % 2048;
      got++;
    end
  end

  task automatic t_regs;
    rdc(OFS_BATCH, BATCH_RST);
    rdc(OFS_AVAIL, 0);
    rdc(OFS_RDPTR, 0);
    wr(8'h20, 32'h5a);
    rdc(8'h20, 0);
    wr(OFS_BATCH, 0);
    rdc(OFS_BATCH, BATCH_MIN);
    wr(OFS_BATCH, 32'h900);
    rdc(OFS_BATCH, BATCH_MAX);
    wr(OFS_BATCH, 32'h800);
    rdc(OFS_BATCH, 32'h800);
  endtask : t_regs

  task automatic t_fetch;
    push(5);
    rdc(OFS_AVAIL, 5);
    wr(OFS_BATCH, 3);
    got = 0;
    wr(OFS_FETCH, 0);
    rdc(OFS_FETCH, 3);
    wait_got(3);
    rdc(OFS_AVAIL, 2);
    rdc(OFS_RDPTR, 3);
    got = 0;
    wr(OFS_FETCH, 0);
    rdc(OFS_FETCH, 2);
    wait_got(2);
    wr(OFS_FETCH, 0);
    rdc(OFS_FETCH, 0);
    rdc(OFS_RDPTR, 5);
    cnt = 0;
  endtask : t_fetch

  task automatic t_ptr;
    wr(OFS_RDPTR, 3);
    rdc(OFS_RDPTR, 3);
    rdc(OFS_AVAIL, 2);
    rp = 3;
    got = 0;
    wr(OFS_FETCH, 0);
    wait_got(2);
    wr(OFS_RDPTR, wp);
    rdc(OFS_AVAIL, 0);
    rp = wp;
    cnt = 0;
  endtask : t_ptr

  task automatic t_ovf_stall;
    push(2049);
    rdc(OFS_AVAIL, 32'h800);
    rdc(OFS_RDPTR, rp);
    rdc(OFS_STAT, 32'h1 << STAT_FULL_BIT);
    @(posedge sys_clk);
    stream_ready <= 1'b0;
    wr(OFS_BATCH, 12);
    got = 0;
    wr(OFS_FETCH, 0);
    repeat (20) @(negedge sys_clk);
    rdc(OFS_STAT, 32'h1 << STAT_BUSY_BIT);
    rdc(OFS_AVAIL, 32'h800 - FIFO_DEPTH - 1);
    @(posedge sys_clk);
    stream_ready <= 1'b1;
    wait_got(12);
    rdc(OFS_STAT, 0);
    rdc(OFS_AVAIL, 32'h800 - 12);
  endtask : t_ovf_stall

  task automatic t_marker;
    @(posedge sys_clk);
    sweep_armed <= 1'b1;
    sweep_gate  <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(mio_oe_n, 0);
    chk(mio_out, 1);
    chk(trig_in, 1);
    chk(buf_gate, 1);
    wr(OFS_GATE, gcfg(MBR_MARKER, 1'b1));
    @(posedge sys_clk);
    sweep_armed <= 1'b0;
    sweep_trig  <= 1'b1;
    sweep_gate  <= 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(mio_out, 1);
    chk(arm_in, 1);
    chk(buf_gate, 0);
    @(posedge sys_clk);
    sweep_trig <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(mio_out, 0);
  endtask : t_marker

  // Edges from line rise to gate rise, then line dropped
  task automatic line_lat(input mbr_gate_mode_e m, output int n);
    wr(OFS_GATE, gcfg(m, 1'b0));
    repeat (2) @(posedge sys_clk);
    peer_en  <= 1'b1;
    peer_drv <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      @(negedge sys_clk);
    end while (buf_gate !== 1'b1 && n < 8);
    @(posedge sys_clk);
    peer_drv <= 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask : line_lat

  // Gate cycles after a short line pulse
  task automatic trig_dur(input mbr_gate_mode_e m, output int n);
    wr(OFS_DUR, 6);
    wr(OFS_GATE, gcfg(m, 1'b0));
    @(posedge sys_clk);
    peer_drv <= 1'b1;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      if (i == 3) peer_drv <= 1'b0;
      @(negedge sys_clk);
      if (buf_gate === 1'b1) n++;
    end
  endtask : trig_dur

  task automatic t_gates;
    line_lat(MBR_EXT, k);
    chk(k, 3);
    chk(buf_gate, 0);
    line_lat(MBR_BURST, k);
    chk(k, 3);
    chk(buf_gate, 0);
    trig_dur(MBR_EXTTRIG, k);
    chk(k, 6);
    trig_dur(MBR_PERIODIC, k);
    chk(k, 6);
  endtask : t_gates

  task automatic t_master;
    int no;
    int ng;
    @(posedge sys_clk);
    peer_en <= 1'b0;
    wr(OFS_PER, 20);
    wr(OFS_DUR, 5);
    wr(OFS_GATE, gcfg(MBR_PERIODIC, 1'b1));
    for (int i = 0; i < 60 && mio_out !== 1'b1; i++) @(negedge sys_clk);
    no = 0;
    ng = 0;
    for (int i = 0; i < 20; i++) begin
      if (mio_out === 1'b1) no++;
      if (buf_gate === 1'b1) ng++;
      @(negedge sys_clk);
    end
    chk(no, START_PULSE_CYC);
    chk(ng, 5);
    chk(mio_out, 1);
    chk(mio_oe_n, 0);
    repeat (8) @(negedge sys_clk);
    @(posedge sys_clk);
    burst_gate <= 1'b1;
    wr(OFS_GATE, gcfg(MBR_BURST, 1'b1));
    repeat (4) @(negedge sys_clk);
    chk(mio_oe_n, 0);
    chk(mio_out, 1);
    @(posedge sys_clk);
    burst_gate <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(mio_out, 0);
  endtask : t_master

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    entry_valid = 1'b0;
    entry_data = '0;
    stream_ready = 1'b1;
    sweep_gate = 1'b0;
    sweep_trig = 1'b0;
    sweep_armed = 1'b0;
    burst_gate = 1'b0;
    peer_en = 1'b0;
    peer_drv = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_fetch();
    t_ptr();
    t_ovf_stall();
    t_marker();
    t_gates();
    t_master();
    results();
  end
endmodule : tb
